// file: bench/fpuexc_chk_asserts.sv
`timescale 1ns/1ps
module fpuexc_chk
    import fpuexc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        op_valid_i,
    input wire logic [3:0]  op_class_i,
    input wire logic        a_snan_i,
    input wire logic        b_snan_i,
    input wire logic        a_inf_i,
    input wire logic        a_zero_i,
    input wire logic        a_sign_i,
    input wire logic        b_sign_i,
    input wire logic        res_sign_i,
    input wire logic        res_tiny_i,
    input wire logic        res_zero_i,
    input wire logic        denorm_support_i,
    input wire logic [63:0] res_o,
    input wire logic        res_valid_o,
    input wire logic [5:0]  cause_o,
    input wire logic        trap_o
);
////////////////////////////////////////////////
    // Mirrors writes only; ops never touch mode or enables
    logic [31:0] sh_reg;
    logic [31:0] msk;
    logic        wr;
    assign msk = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                  {8{wb_sel_i[0]}}};
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
    always_ff @(posedge clk_i) begin
        if (rst_i)
            sh_reg <= CSR_RESET_C;
        else if (wr && wb_ack_o && wb_adr_i == ADDR_CSR_C)
            sh_reg <= (sh_reg & ~msk) | (wb_dat_i & msk);
    end
    function automatic logic [63:0] ovf_f(logic [1:0] m, logic s);
        return {s, (!m || (m[1] && m[0] == s)) ? MAG_INF_C : MAG_MAXF_C};
    endfunction
    function automatic logic [63:0] unf_f(logic [1:0] m, logic s);
        return {m[1] ? m[0] : s, (m[1] && m[0] == s) ? MAG_MINN_C : 63'h0};
    endfunction
////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A write beside an op may overrule cause, so such ops are skipped
    sequence s_op;
        op_valid_i && !wr;
    endsequence
    sequence s_done;
        s_op ##1 res_valid_o;
    endsequence
    AST_ONE_EXC: assert property (s_op |=> $onehot0(cause_o[4:1]))
        else $error("two exceptions at once");
    AST_QNAN: assert property (
        s_done ##0 cause_o[4] |-> res_o == QNAN_C) else $error("not qnan");
    AST_DZ_INF: assert property (
        s_done ##0 cause_o[3] |-> res_o == {$past(a_sign_i ^ b_sign_i),
        MAG_INF_C}) else $error("bad divide-by-zero result");
    AST_DZ_ONLY: assert property (
        s_op ##0 (op_class_i == OP_DIV_C && (a_zero_i || a_inf_i))
        |=> !cause_o[3]) else $error("divide-by-zero raised wrongly");
    AST_SNAN: assert property (
        s_op ##0 (a_snan_i && op_class_i < OP_FMT_MOVE_C) |=> cause_o[4])
        else $error("signaling operand not invalid");
    AST_OVF_DEF: assert property (
        s_done ##0 cause_o[2] |-> res_o == ovf_f(sh_reg[1:0],
        $past(res_sign_i))) else $error("bad overflow result");
    AST_UNF_DEF: assert property (
        s_done ##0 (cause_o[1] && !sh_reg[CSR_FN_BIT_C]) |-> res_o ==
        unf_f(sh_reg[1:0], $past(res_sign_i))) else $error("bad underflow");
    // Invalid and divide-by-zero outrank underflow, so keep them out
    AST_UNF_EN: assert property (
        s_op ##0 (res_tiny_i && !res_zero_i && denorm_support_i
        && sh_reg[8] && op_class_i <= OP_MUL_C && !a_snan_i
        && !b_snan_i && !a_inf_i && !a_zero_i) |=> cause_o[1])
        else $error("tiny result not underflow");
    AST_TRAP: assert property (
        s_op ##1 trap_o |-> cause_o[5] || |(cause_o[4:0] & sh_reg[11:7]))
        else $error("trap without enabled cause");
endmodule // fpuexc_chk
bind fpuexc_detect fpuexc_chk u_fpuexc_chk (.*);

// file: bench/fpuexc_dp_model.sv
`timescale 1ns/1ps
module fpuexc_dp_model
    import fpuexc_pkg::*;
(
    input  wire logic        clk_i,
    output logic             op_valid_o,
    output logic      [3:0]  op_class_o,
    output logic      [18:0] flags_o,
    output logic      [63:0] res_o
);
////////////////////////////////////////////////
    initial begin
        op_valid_o = 1'b0;
        op_class_o = OP_ADD_C;
        flags_o    = 19'h0;
        res_o      = 64'h0;
    end
    // One op per call; flags only qualify the strobe cycle
    task automatic issue(logic [3:0] c, logic [18:0] f, logic [63:0] r);
        @(posedge clk_i);
        op_valid_o <= 1'b1;
        op_class_o <= c;
        flags_o    <= f;
        res_o      <= r;
        @(posedge clk_i);
        op_valid_o <= 1'b0;
        // Inverted afterwards so a late sample is caught
        op_class_o <= ~c;
        flags_o    <= ~f;
        res_o      <= ~r;
        #1;
    endtask
endmodule // fpuexc_dp_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench
    import fpuexc_pkg::*;
;
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin fails++; \
    $display("unexpected at %0t: %h vs %h", $time, g, w); end end
    localparam logic [63:0] RV = 64'h3FF0_0000_0000_0001;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, hit;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF, op_class_i;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        wb_ack_o, op_valid_i, res_valid_o, trap_o;
    logic [63:0] res_i, res_o, e;
    logic [5:0]  cause_o;
    logic [18:0] fl;
    logic        a_snan_i, b_snan_i, a_nan_i, a_inf_i, b_inf_i, a_zero_i;
    logic        b_zero_i, a_sign_i, b_sign_i, a_denorm_i, b_denorm_i;
    logic        fix_ovf_i, res_sign_i, res_zero_i, res_tiny_i, res_huge_i;
    logic        res_inexact_i, denorm_flushed_i, denorm_support_i;
    int          fails = 0, tests_run = 0;
    assign {denorm_support_i, denorm_flushed_i, res_inexact_i, res_huge_i,
            res_tiny_i, res_zero_i, res_sign_i, fix_ovf_i, b_denorm_i,
            a_denorm_i, b_sign_i, a_sign_i, b_zero_i, a_zero_i, b_inf_i,
            a_inf_i, a_nan_i, b_snan_i, a_snan_i} = fl;
    fpuexc_dp_model u_fpuexc_dp_model (
        .clk_i      (clk_i),
        .op_valid_o (op_valid_i),
        .op_class_o (op_class_i),
        .flags_o    (fl),
        .res_o      (res_i)
    );
    fpuexc_detect u_fpuexc_detect (.*);
////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wb(logic we, logic [3:0] a, logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && n++ < 50);
        if (n >= 50) fails++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        #1;
    endtask
    task automatic op(logic [3:0] c, logic [18:0] f);
        u_fpuexc_dp_model.issue(c, f, RV);
    endtask
////////////////////////////////////////////////
    task automatic t_map;
        wb(1'b0, ADDR_CSR_C, 32'h0);
        `CHK(rd, CSR_RESET_C)
        wb(1'b1, 4'hC, 32'hFFFF_FFFF);
        wb(1'b0, 4'hC, 32'h0);
        `CHK(rd, 32'h0)
    endtask
    task automatic t_invalid;
        logic [22:0] cs [11] = '{{OP_ADD_C, 19'h40001},
            {OP_MUL_C, 19'h40002}, {OP_ADD_C, 19'h40118},
            {OP_SUB_C, 19'h40198}, {OP_MUL_C, 19'h40030},
            {OP_DIV_C, 19'h40060}, {OP_DIV_C, 19'h40018},
            {OP_SQRT_C, 19'h40080}, {OP_CVT_FIX_C, 19'h40800},
            {OP_CVT_FIX_C, 19'h40008}, {OP_CVT_FIX_C, 19'h40004}};
        foreach (cs[i]) begin
            op(cs[i][22:19], cs[i][18:0]);
            `CHK({res_valid_o, res_o}, {1'b1, QNAN_C})
            `CHK(cause_o, 6'h10)
        end
        op(OP_SQRT_C, 19'h400A0);
        `CHK({cause_o, res_o}, {6'h00, RV})
        op(OP_FMT_MOVE_C, 19'h40001);
        `CHK(cause_o, 6'h00)
        op(OP_COND_MOVE_C, 19'h40003);
        `CHK(cause_o, 6'h00)
    endtask
    task automatic t_divzero;
        op(OP_DIV_C, 19'h410C0);
        `CHK({cause_o, res_o}, {6'h08, 1'b1, MAG_INF_C})
        op(OP_DIV_C, 19'h40048);
        `CHK(cause_o, 6'h00)
    endtask
    task automatic t_ovf_unf;
        logic [1:0] m;
        logic       s;
        for (int k = 0; k < 8; k++) begin
            m = k[2:1];
            s = k[0];
            wb(1'b1, ADDR_CSR_C, {30'h0, m});
            op(OP_MUL_C, 19'h58000 | {6'h0, s, 12'h0});
            e = {s, (!m || (m[1] && m[0] == s)) ? MAG_INF_C : MAG_MAXF_C};
            `CHK({cause_o, res_o}, {6'h05, e})
            op(OP_MUL_C, 19'h54000 | {6'h0, s, 12'h0});
            e = {m[1] ? m[0] : s, (m[1] && m[0] == s) ? MAG_MINN_C : 63'h0};
            `CHK({cause_o, res_o}, {6'h03, e})
        end
        op(OP_ADD_C, 19'h44000);
        `CHK(cause_o, 6'h00)
        wb(1'b0, ADDR_CSR_C, 32'h0);
        `CHK(rd[6:2], 5'h07)
        wb(1'b1, ADDR_CSR_C, 32'h100);
        op(OP_ADD_C, 19'h44000);
        `CHK({trap_o, cause_o}, 7'h42)
    endtask
    task automatic t_trap;
        wb(1'b1, ADDR_CSR_C, 32'h800);
        op(OP_ADD_C, 19'h40001);
        `CHK({trap_o, res_valid_o}, 2'b10)
        wb(1'b0, ADDR_CSR_C, 32'h0);
        `CHK(rd[6:2], 5'h00)
        hit = 1'b0;
        // Write trap pulses inside the bus cycle, so watch alongside it
        fork
            wb(1'b1, ADDR_CSR_C, 32'h10800);
            repeat (4) begin
                @(posedge clk_i);
                #1 hit = hit | trap_o;
            end
        join
        `CHK(hit, 1'b1)
        wb(1'b1, ADDR_CSR_C, 32'h0);
        op(OP_ADD_C, 19'h00200);
        `CHK({trap_o, cause_o}, 7'h60)
        wb(1'b1, ADDR_CSR_C, 32'h0100_0000);
        op(OP_ADD_C, 19'h20200);
        `CHK({trap_o, cause_o}, 7'h01)
    endtask
////////////////////////////////////////////////
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_map();
        t_invalid();
        t_divzero();
        t_ovf_unf();
        t_trap();
        tally_and_finish();
    end
    // Work is about 150 cycles; the 4000-cycle limit, over 25 times that, marks a hang
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule // testbench

// file: logic/fpuexc_default.sv
`timescale 1ns/1ps
// Default-result selector for overflow and underflow
module fpuexc_default
    import fpuexc_pkg::*;
(
    input  wire logic [1:0]  rmode_i,
    input  wire logic        sign_i,
    input  wire logic        ovf_i,
    input  wire logic        flush_near_i,
    output logic      [63:0] ovf_res_o,
    output logic      [63:0] unf_res_o
);

    always_comb begin
        unique case (rmode_i)
            RM_NEAREST_C: ovf_res_o = {sign_i, MAG_INF_C};
            RM_ZERO_C:    ovf_res_o = {sign_i, MAG_MAXF_C};
            RM_PLUS_C:    ovf_res_o = sign_i ? {1'b1, MAG_MAXF_C}
                                             : {1'b0, MAG_INF_C};
            RM_MINUS_C:   ovf_res_o = sign_i ? {1'b1, MAG_INF_C}
                                             : {1'b0, MAG_MAXF_C};
        endcase
    end

    always_comb begin
        unf_res_o = {sign_i, 63'h0};
        // Directed modes only when flush-to-nearest is clear
        if (!flush_near_i) begin
            if (rmode_i == RM_PLUS_C) begin
                unf_res_o = sign_i ? 64'h0 : {1'b0, MAG_MINN_C};
            end else if (rmode_i == RM_MINUS_C) begin
                unf_res_o = sign_i ? {1'b1, MAG_MINN_C}
                                   : {1'b1, 63'h0};
            end
        end
    end

endmodule // fpuexc_default

// file: logic/fpuexc_detect.sv
`timescale 1ns/1ps
module fpuexc_detect
    import fpuexc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Datapath side
    input  wire logic        op_valid_i,
    input  wire logic [3:0]  op_class_i,
    input  wire logic        a_snan_i,
    input  wire logic        b_snan_i,
    input  wire logic        a_nan_i,
    input  wire logic        a_inf_i,
    input  wire logic        b_inf_i,
    input  wire logic        a_zero_i,
    input  wire logic        b_zero_i,
    input  wire logic        a_sign_i,
    input  wire logic        b_sign_i,
    input  wire logic        a_denorm_i,
    input  wire logic        b_denorm_i,
    input  wire logic        fix_ovf_i,
    input  wire logic        res_sign_i,
    input  wire logic        res_zero_i,
    input  wire logic        res_tiny_i,
    input  wire logic        res_huge_i,
    input  wire logic        res_inexact_i,
    input  wire logic        denorm_flushed_i,
    input  wire logic        denorm_support_i,
    input  wire logic [63:0] res_i,
    output logic      [63:0] res_o,
    output logic             res_valid_o,
    output logic      [5:0]  cause_o,
    output logic             trap_o
);

    ////////////////////////////////////////////////////////////////////////
    // Control/status register and decode

    logic [31:0] fp_control_status_reg;
    logic [63:0] res_reg;
    logic        res_valid_reg;
    logic        trap_reg;
    logic        ack_reg;

    logic [1:0] rmode;
    logic [4:0] enables;
    logic       flush_to_zero_ctrl;
    logic       flush_override_ctrl;
    logic       flush_to_nearest_ctrl;

    assign rmode                 = fp_control_status_reg[CSR_RMODE_LSB_C +: 2];
    assign enables               = fp_control_status_reg[CSR_ENABLE_LSB_C +: 5];
    assign flush_to_zero_ctrl    = fp_control_status_reg[CSR_FS_BIT_C];
    assign flush_override_ctrl   = fp_control_status_reg[CSR_FO_BIT_C];
    assign flush_to_nearest_ctrl = fp_control_status_reg[CSR_FN_BIT_C];

    logic wb_req;
    logic wb_wr_csr;
    assign wb_req    = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr_csr = wb_req && wb_we_i && (wb_adr_i == ADDR_CSR_C);

    ////////////////////////////////////////////////////////////////////////
    // Exception detection

    logic is_move;
    logic is_div;
    logic sub_eff;
    logic inv;
    logic dz;
    logic tiny;
    logic ovf;
    logic unf;
    logic inx;
    logic emul;
    logic any_denorm;

    assign is_move = (op_class_i == OP_FMT_MOVE_C) ||
                     (op_class_i == OP_COND_MOVE_C);
    assign is_div  = (op_class_i == OP_DIV_C);
    // Effective subtraction: signs differ for add, match for subtract
    assign sub_eff = (op_class_i == OP_ADD_C) ? (a_sign_i ^ b_sign_i)
                                              : !(a_sign_i ^ b_sign_i);
    assign any_denorm = a_denorm_i || b_denorm_i;

    always_comb begin
        inv = (a_snan_i || b_snan_i) && !is_move;
        unique case (op_class_i)
            OP_ADD_C, OP_SUB_C:
                inv = inv || (a_inf_i && b_inf_i && sub_eff);
            OP_MUL_C:
                inv = inv || (a_zero_i && b_inf_i)
                          || (a_inf_i && b_zero_i);
            OP_DIV_C:
                inv = inv || (a_zero_i && b_zero_i)
                          || (a_inf_i && b_inf_i);
            OP_SQRT_C:
                inv = inv || (a_sign_i && !a_zero_i && !a_nan_i);
            OP_CVT_FIX_C:
                inv = inv || a_inf_i || a_nan_i || fix_ovf_i;
            default: ;
        endcase
    end

    // Finite nonzero dividend only; NaN dividend already handled
    assign dz = is_div && b_zero_i && !a_zero_i && !a_inf_i
                && !a_nan_i && !inv;

    // Tininess uses post-rounding flag from the datapath
    assign tiny = res_tiny_i && !res_zero_i && !inv && !dz;
    assign ovf  = res_huge_i && !inv && !dz;

    // Underflow enable relaxes the accuracy condition
    assign unf = enables[EXC_UNDERFLOW_C] ? tiny
                                          : (tiny && res_inexact_i);

    // Inexact can stand alone or join overflow or underflow, never inv/dz
    assign inx = !inv && !dz && (res_inexact_i
                 || (ovf && !enables[EXC_OVERFLOW_C])
                 || (denorm_flushed_i && flush_to_zero_ctrl));

    // Unhandled denormals trap to software unless flush-to-zero, or flush override with flush-to-nearest, is set
    assign emul = !flush_to_zero_ctrl && !denorm_support_i && !is_move
                  && (any_denorm || res_tiny_i)
                  && !(flush_override_ctrl && flush_to_nearest_ctrl);

    logic [5:0] cause_next;
    assign cause_next = {emul, inv, dz, ovf, unf, inx};

    logic op_trap;
    assign op_trap = emul || |(cause_next[4:0] & enables);

    ////////////////////////////////////////////////////////////////////////
    // Default result selection

    logic [63:0] ovf_res;
    logic [63:0] unf_res;

    fpuexc_default u_default (
        .rmode_i      (rmode),
        .sign_i       (res_sign_i),
        .ovf_i        (ovf),
        .flush_near_i (flush_to_nearest_ctrl),
        .ovf_res_o    (ovf_res),
        .unf_res_o    (unf_res)
    );

    logic [63:0] res_next;
    always_comb begin
        res_next = res_i;
        if (inv) begin
            res_next = QNAN_C;
        end else if (dz) begin
            res_next = {a_sign_i ^ b_sign_i, MAG_INF_C};
        end else if (ovf) begin
            res_next = ovf_res;
        end else if (unf) begin
            res_next = unf_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_reg       <= 64'h0;
            res_valid_reg <= 1'b0;
        end else begin
            res_valid_reg <= op_valid_i && !op_trap;
            if (op_valid_i && !op_trap) begin
                res_reg <= res_next;
            end
        end
    end

    // Software writes win over a same-cycle op on cause; flags OR in unless the op traps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fp_control_status_reg <= CSR_RESET_C;
        end else begin
            if (wb_wr_csr) begin
                for (int i = 0; i < 4; i++) begin
                    if (wb_sel_i[i]) begin
                        fp_control_status_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                    end
                end
            end else if (op_valid_i) begin
                fp_control_status_reg[CSR_CAUSE_LSB_C +: 6] <= cause_next;
            end
            // Same-cycle write replaces old flags, the op's set still wins
            if (op_valid_i && !op_trap) begin
                fp_control_status_reg[CSR_FLAGS_LSB_C +: 5] <=
                    ((wb_wr_csr && wb_sel_i[0])
                        ? wb_dat_i[CSR_FLAGS_LSB_C +: 5]
                        : fp_control_status_reg[CSR_FLAGS_LSB_C +: 5])
                    | cause_next[4:0];
            end
        end
    end

    // Trap from op, or from a write that leaves cause and enable set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trap_reg <= 1'b0;
        end else begin
            trap_reg <= (op_valid_i && op_trap) || (wb_wr_csr &&
                (wb_dat_i[CSR_CAUSE_LSB_C + EXC_EMUL_C] ||
                 |(wb_dat_i[CSR_CAUSE_LSB_C +: 5]
                   & wb_dat_i[CSR_ENABLE_LSB_C +: 5])));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone read path, one wait state

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_reg <= wb_req;
            if (wb_req) begin
                unique case (wb_adr_i)
                    ADDR_CSR_C:    wb_dat_o <= fp_control_status_reg;
                    ADDR_RESULT_C: wb_dat_o <= res_reg[31:0];
                    ADDR_STATUS_C: wb_dat_o <= {30'h0, trap_reg,
                                                res_valid_reg};
                    default:       wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    assign wb_ack_o    = ack_reg;
    assign res_o       = res_reg;
    assign res_valid_o = res_valid_reg;
    assign cause_o     = fp_control_status_reg[CSR_CAUSE_LSB_C +: 6];
    assign trap_o      = trap_reg;

endmodule // fpuexc_detect

// file: logic/fpuexc_pkg.sv
package fpuexc_pkg;

    // Rounding-mode codes
    localparam logic [1:0] RM_NEAREST_C    = 2'h0;
    localparam logic [1:0] RM_ZERO_C       = 2'h1;
    localparam logic [1:0] RM_PLUS_C       = 2'h2;
    localparam logic [1:0] RM_MINUS_C      = 2'h3;

    // Operation classes presented by the datapath
    localparam logic [3:0] OP_ADD_C        = 4'h0;
    localparam logic [3:0] OP_SUB_C        = 4'h1;
    localparam logic [3:0] OP_MUL_C        = 4'h2;
    localparam logic [3:0] OP_DIV_C        = 4'h3;
    localparam logic [3:0] OP_SQRT_C       = 4'h4;
    localparam logic [3:0] OP_CVT_FIX_C    = 4'h5;
    localparam logic [3:0] OP_CVT_FLT_C    = 4'h6;
    localparam logic [3:0] OP_FMT_MOVE_C   = 4'h7;
    localparam logic [3:0] OP_COND_MOVE_C  = 4'h8;

    // Five IEEE cause bits plus emulation request
    localparam int EXC_INEXACT_C   = 0;
    localparam int EXC_UNDERFLOW_C = 1;
    localparam int EXC_OVERFLOW_C  = 2;
    localparam int EXC_DIVZERO_C   = 3;
    localparam int EXC_INVALID_C   = 4;
    localparam int EXC_EMUL_C      = 5;

    // Field positions inside the control/status word
    localparam int CSR_RMODE_LSB_C  = 0;
    localparam int CSR_FLAGS_LSB_C  = 2;
    localparam int CSR_ENABLE_LSB_C = 7;
    localparam int CSR_CAUSE_LSB_C  = 12;
    localparam int CSR_FN_BIT_C     = 18;
    localparam int CSR_FO_BIT_C     = 22;
    localparam int CSR_FS_BIT_C     = 24;

    // Wishbone map (word addresses are byte offsets)
    localparam logic [3:0] ADDR_CSR_C    = 4'h0;
    localparam logic [3:0] ADDR_RESULT_C = 4'h4;
    localparam logic [3:0] ADDR_STATUS_C = 4'h8;

    localparam logic [31:0] CSR_RESET_C  = 32'h0000_0000;

    // Double-precision encodings
    localparam logic [62:0] MAG_INF_C    = 63'h7FF0_0000_0000_0000;
    localparam logic [62:0] MAG_MAXF_C   = 63'h7FEF_FFFF_FFFF_FFFF;
    localparam logic [62:0] MAG_MINN_C   = 63'h0010_0000_0000_0000;
    localparam logic [63:0] QNAN_C       = 64'h7FF8_0000_0000_0000;

endpackage
